// ==== verilog/apo_pkg.sv ====
/*
 Shared constants and the sample word carrier for the converter output port.
 Assumes a single 200 MHz system clock and a synchronous active-low reset.
*/
package apo_pkg;

   // Word layout.
   localparam int unsigned WORD_W      = 12;
   localparam int unsigned TOP_IDX     = 11;
   localparam int unsigned BOTTOM_IDX  = 0;

   // Full-cycle result stages before the half-cycle output load.
   localparam int unsigned PIPE_STAGES = 3;

   // Flip-flops in each pin synchroniser.
   localparam int unsigned SYNC_STAGES = 2;

   // Pins handled by the synchroniser: sample clock, enable, format select.
   localparam int unsigned PIN_COUNT   = 3;
   localparam int unsigned PIN_CLK     = 0;
   localparam int unsigned PIN_OE_N    = 1;
   localparam int unsigned PIN_FLIP    = 2;

   // Reset values. A low level stands for an unconnected, pulled-down pin.
   localparam logic [PIN_COUNT-1:0] PIN_RESET = 3'h0;
   localparam logic                 BIT_RESET = 1'h0;

   typedef struct packed {
      logic                sample_word_top_bit;
      logic [TOP_IDX-1:0]  lower_bits;
   } apo_word_s;

   localparam apo_word_s WORD_RESET = 12'h000;

endpackage

// ==== verilog/apo_pin_sync.sv ====
/*
 Two-flip-flop synchroniser for a group of asynchronous pins.
 Assumes the pins are levels that stay stable for many system clocks.
*/
`timescale 1ns/100ps
module apo_pin_sync (
   // Clock and reset.
   input  wire logic                          clk,
   input  wire logic                          rstn,
   // Asynchronous pin levels.
   input  wire logic [apo_pkg::PIN_COUNT-1:0] pin_async,
   // Levels in the clock domain.
   output logic      [apo_pkg::PIN_COUNT-1:0] pin_sync
);

   logic [apo_pkg::PIN_COUNT-1:0] meta_reg;
   logic [apo_pkg::PIN_COUNT-1:0] meta_next;
   logic [apo_pkg::PIN_COUNT-1:0] hold_reg;
   logic [apo_pkg::PIN_COUNT-1:0] hold_next;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_next = pin_async;
      hold_next = meta_reg;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_reg <= apo_pkg::PIN_RESET;
         hold_reg <= apo_pkg::PIN_RESET;
      end else begin
         meta_reg <= meta_next;
         hold_reg <= hold_next;
      end
   end

   assign pin_sync = hold_reg;

endmodule // apo_pin_sync

// ==== verilog/apo_output_port.sv ====
/*
 Digital output port of a pipelined sampling converter: result pipeline,
 half-cycle output load, format select, three-state control and aperture.
 Assumes the conversion core offers its raw word on the system clock and
 that the sample clock pin is far slower than the system clock.
*/
`timescale 1ns/100ps
module apo_output_port (
   // System clock and reset.
   input  wire logic              clk,
   input  wire logic              rstn,
   // Pins from the outside world.
   input  wire logic              sample_clk_pin,
   input  wire logic              out_enable_n_pin,
   input  wire logic              msb_flip_select,
   // Raw result from the conversion core.
   input  wire apo_pkg::apo_word_s raw_word,
   // Parallel data port and its shared output enable.
   output apo_pkg::apo_word_s     sample_word,
   output logic                   sample_word_oe,
   // Sample point and sample event.
   output logic                   aperture,
   output logic                   sample_taken
);

   logic [apo_pkg::PIN_COUNT-1:0] pin_sync;

   // Pins come from outside the clock domain.
   apo_pin_sync u_sync (
      .clk       (clk),
      .rstn      (rstn),
      .pin_async ({msb_flip_select, out_enable_n_pin, sample_clk_pin}),
      .pin_sync  (pin_sync)
   );

   logic clk_level;
   logic oe_n_level;
   logic flip_level;

   assign clk_level  = pin_sync[apo_pkg::PIN_CLK];
   assign oe_n_level = pin_sync[apo_pkg::PIN_OE_N];
   assign flip_level = pin_sync[apo_pkg::PIN_FLIP];

   // Edge detection on the synchronised sample clock.
   logic clk_prev_reg;
   logic clk_prev_next;
   logic rise;
   logic fall;

   assign rise = clk_level & ~clk_prev_reg;
   assign fall = ~clk_level & clk_prev_reg;

   always_comb begin
      clk_prev_next = clk_level;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         clk_prev_reg <= apo_pkg::BIT_RESET;
      end else begin
         clk_prev_reg <= clk_prev_next;
      end
   end

   // Result pipeline, shifted on each rising sample edge.
   apo_pkg::apo_word_s stage_reg  [apo_pkg::PIPE_STAGES];
   apo_pkg::apo_word_s stage_next [apo_pkg::PIPE_STAGES];

   always_comb begin
      stage_next[0] = rise ? raw_word : stage_reg[0];
   end

   genvar gi;
   generate
      for (gi = 1; gi < apo_pkg::PIPE_STAGES; gi++) begin : g_pipe
         always_comb begin
            stage_next[gi] = rise ? stage_reg[gi-1] : stage_reg[gi];
         end
      end
      for (gi = 0; gi < apo_pkg::PIPE_STAGES; gi++) begin : g_pipe_ff
         always_ff @(posedge clk) begin
            if (!rstn) begin
               stage_reg[gi] <= apo_pkg::WORD_RESET;
            end else begin
               stage_reg[gi] <= stage_next[gi];
            end
         end
      end
   endgenerate

   // Format select is applied as the word leaves the pipeline.
   function automatic apo_pkg::apo_word_s format_word(input apo_pkg::apo_word_s w,
                                                      input logic flip);
      apo_pkg::apo_word_s f;
      f = w;
      f.sample_word_top_bit = w.sample_word_top_bit ^ flip;
      return f;
   endfunction

   // Output register loads on the falling edge, half a cycle after the
   // last shift, which gives the 2.5 cycle latency from the sample edge.
   apo_pkg::apo_word_s out_reg;
   apo_pkg::apo_word_s out_next;
   logic               oe_reg;
   logic               oe_next;
   logic               aperture_reg;
   logic               aperture_next;
   logic               taken_reg;
   logic               taken_next;

   always_comb begin
      out_next      = out_reg;
      if (fall) begin
         out_next = format_word(stage_reg[apo_pkg::PIPE_STAGES-1], flip_level);
      end
      // A pulled-down enable resets to low, so the port drives by default.
      oe_next       = ~oe_n_level;
      aperture_next = clk_level;
      taken_next    = rise;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_reg      <= apo_pkg::WORD_RESET;
         oe_reg       <= apo_pkg::BIT_RESET;
         aperture_reg <= apo_pkg::BIT_RESET;
         taken_reg    <= apo_pkg::BIT_RESET;
      end else begin
         out_reg      <= out_next;
         oe_reg       <= oe_next;
         aperture_reg <= aperture_next;
         taken_reg    <= taken_next;
      end
   end

   // The word keeps updating on each fall while three-stated, so re-enabling
   // shows the latest word at once rather than waiting for the next update.
   assign sample_word    = out_reg;
   assign sample_word_oe = oe_reg;
   assign aperture       = aperture_reg;
   assign sample_taken   = taken_reg;

endmodule // apo_output_port

// ==== bench/apo_chk.sv ====
/* Port checker for the output port; assumes pins are low in reset. */
`timescale 1ns/100ps
module apo_chk (
   // Clock, reset and pins.
   input wire logic clk,
   input wire logic rstn,
   input wire logic sample_clk_pin,
   input wire logic out_enable_n_pin,
   input wire logic msb_flip_select,
   // Data and status.
   input wire apo_pkg::apo_word_s raw_word,
   input wire apo_pkg::apo_word_s sample_word,
   input wire logic sample_word_oe,
   input wire logic aperture,
   input wire logic sample_taken
);
   apo_pkg::apo_word_s p0_reg, p1_reg, p2_reg, raw_d_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Mirror of the result pipeline, one shift per sample taken.
   // The core word is kept one cycle so the shift sees what the capture edge took.
   always_ff @(posedge clk) begin
      raw_d_reg <= raw_word;
      if (!rstn) begin
         {p0_reg, p1_reg, p2_reg} <= '0;
      end else if (sample_taken) begin
         {p0_reg, p1_reg, p2_reg} <= {raw_d_reg, p0_reg, p1_reg};
      end
   end
   sequence s_cap;
      ##3 $rose(aperture) ##0 sample_taken;
   endsequence
   AST_CAP: assert property ($rose(sample_clk_pin) |-> s_cap)
      else $error("capture late");
   AST_FALL: assert property ($fell(sample_clk_pin) |-> ##3 $fell(aperture))
      else $error("aperture fall late");
   AST_HOLD: assert property ($changed(sample_word) |-> $fell(aperture))
      else $error("word moved");
   AST_VAL: assert property (
      $fell(aperture) |-> sample_word == {p2_reg[11] ^ $past(msb_flip_select, 3), p2_reg[10:0]})
      else $error("word value");
   AST_OE: assert property (
      $changed(sample_word_oe) |-> sample_word_oe == !$past(out_enable_n_pin, 3))
      else $error("enable timing");
   AST_DEF: assert property ($rose(rstn) && !out_enable_n_pin |-> ##[1:4] sample_word_oe)
      else $error("default enable");
endmodule // apo_chk
bind apo_output_port apo_chk u_chk (
   .clk              (clk),
   .rstn             (rstn),
   .sample_clk_pin   (sample_clk_pin),
   .out_enable_n_pin (out_enable_n_pin),
   .msb_flip_select  (msb_flip_select),
   .raw_word         (raw_word),
   .sample_word      (sample_word),
   .sample_word_oe   (sample_word_oe),
   .aperture         (aperture),
   .sample_taken     (sample_taken)
);

// ==== bench/apo_host.sv ====
/* Host capture model; assumes it shares the system clock. */
`timescale 1ns/100ps
module apo_host (
   // Clock and port.
   input wire logic clk,
   input wire logic aperture,
   input wire logic oe,
   input wire apo_pkg::apo_word_s word,
   // Captured word.
   output apo_pkg::apo_word_s got
);
   logic ap_d = 1'h0;
   // A released bus shows the inverse of the last word, never a held value.
   always @(posedge clk) begin
      ap_d <= aperture;
      if (ap_d && !aperture) got <= oe ? word : ~got;
   end
endmodule // apo_host

// ==== bench/tb_adc_parallel_output_port.sv ====
/* Bench for the output port; assumes the host model and bound checker. */
`timescale 1ns/100ps
module tb_adc_parallel_output_port;
   logic clk = 1'h0, rstn = 1'h0, sclk = 1'h0, oe_n = 1'h0, flip = 1'h0, oe, ap, tk;
   apo_pkg::apo_word_s raw = '0, word, got;
   int failures = 0, checked = 0, cyc = 0;
   always #2.5 clk = ~clk;
   apo_output_port u_dut (.clk(clk), .rstn(rstn), .sample_clk_pin(sclk),
      .out_enable_n_pin(oe_n), .msb_flip_select(flip), .raw_word(raw),
      .sample_word(word), .sample_word_oe(oe), .aperture(ap), .sample_taken(tk));
   apo_host u_host (.clk(clk), .aperture(ap), .oe(oe), .word(word), .got(got));
   task chk(string n, logic [11:0] e, logic [11:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("Error %s exp %h got %h", n, e, s);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Raw is changed just after a fall so the three-fall latency count is exact.
   task t_word(logic [11:0] v, logic f);
      logic [11:0] p;
      p = raw;
      @(negedge ap);
      @(posedge clk) #1 raw = v;
      flip = f;
      repeat (2) @(negedge ap);
      @(posedge clk) #1 chk("early", {p[11] ^ f, p[10:0]}, word);
      @(negedge ap);
      @(posedge clk) #1 chk("word", {v[11] ^ f, v[10:0]}, word);
      chk("host", {v[11] ^ f, v[10:0]}, got);
      $display("word test %h done", v);
   endtask
   task t_oe;
      @(posedge clk) #1 oe_n = 1;
      repeat (4) @(posedge clk);
      #1 chk("oe off", 12'h000, {11'h000, oe});
      oe_n = 0;
      repeat (4) @(posedge clk);
      #1 chk("oe on", 12'h001, {11'h000, oe});
      $display("enable test done");
   endtask
   task t_default;
      repeat (4) @(posedge clk);
      #1 chk("oe default", 12'h001, {11'h000, oe});
      $display("default test done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         stop_test;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rstn = 1'h1;
      t_default;
      t_word(12'h800, 0);
      t_word(12'h800, 1);
      t_word(12'h001, 1);
      t_word(12'h7fe, 0);
      t_oe;
      stop_test;
   end
   initial begin
      wait (rstn);
      forever begin
         repeat (134) @(posedge clk);
         #1 sclk = ~sclk;
      end
   end
endmodule // tb_adc_parallel_output_port
